// ===== hdl/fpc_debounce.v
// level debouncer: output follows input after it is stable for a set time
`timescale 1ns/100ps
`include "fpc_consts.vh"
module fpc_debounce #(
  parameter integer STABLE_CYC = `FPC_DEB_CYC
) (
  // clock and reset
  input  wire clk_i,
  input  wire rst_i,
  // raw and clean level
  input  wire raw_i,
  output reg  level_o
);
  reg  [20:0] cnt_reg;

  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= 21'h000000;
      level_o <= 1'b0;
    end else if (raw_i == level_o) begin
      cnt_reg <= 21'h000000;
    end else if (cnt_reg == STABLE_CYC[20:0] - 21'h000001) begin
      cnt_reg <= 21'h000000;
      level_o <= raw_i;
    end else begin
      cnt_reg <= cnt_reg + 21'h000001;
    end
  end
endmodule // fpc_debounce

// ===== hdl/fpc_front_panel.v
// front panel control: buttons, reset, nmi, identify and status leds
//
// Function
// - debounced power button drives chipset request
// - locked power press: violation event, no action
// - power button beats reset and sleep buttons
// - reset button needs 25 ms stable level
// - accepted reset press starts system reset
// - locked reset press: violation event, no reset
// - reset button ignored while sleeping
// - nmi press gives 200 ms pulse, logs event
// - identify state survives host resets, starts off
// - default command turn-on arms 15 s timeout
// - command timeout 1 to 254 seconds
// - command can turn identify off at once
// - button toggles identify, no timeout
// - identify leds off normally, blink active
// - status led colour from fault state; both off while not ready or during an nmi pulse
// - critical faults give solid amber
// - non-critical faults and intrusion: blinking amber
// - disabled cpu or memory: blinking green
// - intrusion readable, change raises event
// - secure mode blocks power-down, reset; sleep allowed
// - no button power-up when locked
// - system reset held while button pressed
`timescale 1ns/100ps
`include "fpc_consts.vh"
module fpc_front_panel #(
  parameter integer DEB_CYC   = `FPC_DEB_CYC,
  parameter integer NMI_CYC   = `FPC_NMI_CYC,
  parameter integer SEC_CYC   = `FPC_SEC_CYC,
  parameter integer BLINK_CYC = `FPC_BLINK_CYC
) (
  // clock and reset (reset only at standby power-up)
  input  wire        clk_i,
  input  wire        rst_i,
  // wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [3:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // front panel inputs, active high when pressed
  input  wire        pwr_button_i,
  input  wire        rst_button_i,
  input  wire        nmi_button_i,
  input  wire        id_button_i,
  input  wire        sleep_button_i,
  input  wire        intrusion_i,
  // platform state
  input  wire        secure_mode_i,
  input  wire        panel_lockout_i,
  input  wire        system_on_i,
  input  wire        sleep_state_i,
  // outputs to chipset and system
  output reg         power_button_request_out_o,
  output reg         sleep_request_o,
  output reg         sys_reset_o,
  output reg         nmi_o,
  // leds
  output reg         id_led_front_o,
  output reg         id_led_rear_o,
  output reg         status_green_o,
  output reg         status_amber_o
);
  wire        pwr_db;
  wire        rst_db;
  wire        nmi_db;
  wire        id_db;
  wire        slp_db;
  wire        intr_db;
  wire [5:0]  raw_bus;
  wire [5:0]  db_bus;
  reg  [5:0]  db_q_reg;
  reg  [2:0]  ctrl_reg;
  reg  [3:0]  fault_reg;
  reg  [2:0]  event_reg;
  reg  [2:0]  event_next;
  reg         id_on_reg;
  reg         id_timed_reg;
  reg  [7:0]  id_secs_reg;
  reg  [25:0] sec_cnt_reg;
  reg  [23:0] nmi_cnt_reg;
  reg  [24:0] blink_cnt_reg;
  reg         blink_reg;
  reg         rst_hold_reg;
  reg         lock_pwr;
  reg         lock_rst;
  reg  [31:0] rd_data;
  wire        wb_req;
  wire        wb_wr;
  wire        wr_ctrl;
  wire        wr_ident;
  wire        wr_event;
  wire        wr_fault;
  wire        rst_go;
  wire        viol_set;
  wire        id_cmd_off;
  wire        id_cmd_def;
  wire        sec_tick;
  wire        blink_wrap;
  wire        nmi_done;

  assign raw_bus = {intrusion_i, sleep_button_i, id_button_i,
                    nmi_button_i, rst_button_i, pwr_button_i};
  assign {intr_db, slp_db, id_db, nmi_db, rst_db, pwr_db} = db_bus;

  // one debouncer per input, all with the same stable time
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : g_deb
      fpc_debounce #(
        .STABLE_CYC (DEB_CYC)
      ) u_deb (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .raw_i   (raw_bus[gi]),
        .level_o (db_bus[gi])
      );
    end
  endgenerate

  wire pwr_rise  = db_bus[0] & ~db_q_reg[0];
  wire rst_rise  = db_bus[1] & ~db_q_reg[1];
  wire nmi_rise  = db_bus[2] & ~db_q_reg[2];
  wire id_rise   = db_bus[3] & ~db_q_reg[3];
  wire intr_chg  = db_bus[5] ^ db_q_reg[5];

  // secure mode and force protect; lockout pin blocks power-up only
  always @* begin
    lock_pwr = secure_mode_i | ctrl_reg[`FPC_CTRL_PWR_PROT] |
               (~system_on_i & panel_lockout_i);
    lock_rst = secure_mode_i | ctrl_reg[`FPC_CTRL_RST_PROT];
  end

  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr  = wb_req & wb_we_i & wb_sel_i[0];

  // one strobe per writable register, all on the taking edge
  assign wr_ctrl  = wb_wr & (wb_adr_i == `FPC_ADR_CTRL);
  assign wr_ident = wb_wr & (wb_adr_i == `FPC_ADR_IDENT);
  assign wr_event = wb_wr & (wb_adr_i == `FPC_ADR_EVENT);
  assign wr_fault = wb_wr & (wb_adr_i == `FPC_ADR_FAULT);

  // a held power press wins over a new reset press
  assign rst_go   = rst_rise & ~lock_rst & ~sleep_state_i & ~pwr_db;
  // a reset press in sleep is ignored, so it raises no violation either
  assign viol_set = (pwr_rise & lock_pwr) | (rst_rise & lock_rst & ~sleep_state_i);

  assign id_cmd_off = (wb_dat_i[7:0] == `FPC_ID_OFF_CMD);
  assign id_cmd_def = (wb_dat_i[7:0] == `FPC_ID_DEFAULT);
  assign sec_tick   = (sec_cnt_reg == SEC_CYC[25:0] - 26'h0000001);
  assign blink_wrap = (blink_cnt_reg == BLINK_CYC[24:0] - 25'h0000001);
  assign nmi_done   = (nmi_cnt_reg == 24'h000000);

  // event flags: set wins over clear on the write-one-to-clear path
  always @* begin
    event_next = event_reg;
    if (wr_event)
      event_next = event_reg & ~wb_dat_i[2:0];
    if (viol_set)
      event_next[`FPC_EV_VIOL] = 1'b1;
    if (nmi_rise)
      event_next[`FPC_EV_NMI] = 1'b1;
    if (intr_chg && ctrl_reg[`FPC_CTRL_INTR_EN])
      event_next[`FPC_EV_INTR] = 1'b1;
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      db_q_reg  <= 6'h00;
      event_reg <= 3'h0;
    end else begin
      db_q_reg  <= db_bus;
      event_reg <= event_next;
    end
  end

  // ack lasts one cycle because a taken request masks itself
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? rd_data : 32'h00000000;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg  <= 3'h0;
      fault_reg <= 4'h0;
    end else begin
      if (wr_ctrl)
        ctrl_reg <= wb_dat_i[2:0];
      if (wr_fault)
        fault_reg <= wb_dat_i[3:0];
    end
  end

  // power request: power button passes straight through unless locked
  always @(posedge clk_i) begin
    if (rst_i) begin
      power_button_request_out_o <= 1'b0;
      sleep_request_o            <= 1'b0;
    end else begin
      power_button_request_out_o <= pwr_db & ~lock_pwr;
      // power press masks any held sleep request
      sleep_request_o <= slp_db & ~pwr_db;
    end
  end

  // system reset held as long as the button is held
  always @(posedge clk_i) begin
    if (rst_i) begin
      rst_hold_reg <= 1'b0;
      sys_reset_o  <= 1'b0;
    end else begin
      if (rst_go)
        rst_hold_reg <= 1'b1;
      else if (!rst_db)
        rst_hold_reg <= 1'b0;
      sys_reset_o <= rst_hold_reg | rst_go;
    end
  end

  // nmi pulse; a press during a pulse restarts it
  always @(posedge clk_i) begin
    if (rst_i) begin
      nmi_cnt_reg <= 24'h000000;
      nmi_o       <= 1'b0;
    end else if (nmi_rise) begin
      nmi_cnt_reg <= NMI_CYC[23:0] - 24'h000001;
      nmi_o       <= 1'b1;
    end else if (!nmi_done) begin
      nmi_cnt_reg <= nmi_cnt_reg - 24'h000001;
    end else begin
      nmi_o <= 1'b0;
    end
  end

  // identify: only standby reset clears it, host resets do not reach here
  always @(posedge clk_i) begin
    if (rst_i) begin
      id_on_reg    <= 1'b0;
      id_timed_reg <= 1'b0;
      id_secs_reg  <= 8'h00;
      sec_cnt_reg  <= 26'h0000000;
    end else if (wr_ident) begin
      sec_cnt_reg <= 26'h0000000;
      if (id_cmd_off) begin
        id_on_reg    <= 1'b0;
        id_timed_reg <= 1'b0;
      end else if (id_cmd_def) begin
        id_on_reg    <= 1'b1;
        id_timed_reg <= 1'b1;
        id_secs_reg  <= `FPC_ID_DEF_S;
      end else begin
        id_on_reg    <= 1'b1;
        id_timed_reg <= 1'b1;
        id_secs_reg  <= wb_dat_i[7:0];
      end
    end else if (id_rise) begin
      id_on_reg    <= ~id_on_reg;
      id_timed_reg <= 1'b0;
    end else if (id_on_reg && id_timed_reg) begin
      if (sec_tick) begin
        sec_cnt_reg <= 26'h0000000;
        if (id_secs_reg == 8'h01) begin
          id_on_reg    <= 1'b0;
          id_timed_reg <= 1'b0;
        end
        id_secs_reg <= id_secs_reg - 8'h01;
      end else begin
        sec_cnt_reg <= sec_cnt_reg + 26'h0000001;
      end
    end
  end

  // shared blink; half period each phase
  always @(posedge clk_i) begin
    if (rst_i) begin
      blink_cnt_reg <= 25'h0000000;
      blink_reg     <= 1'b0;
    end else if (blink_wrap) begin
      blink_cnt_reg <= 25'h0000000;
      blink_reg     <= ~blink_reg;
    end else begin
      blink_cnt_reg <= blink_cnt_reg + 25'h0000001;
    end
  end

  // identify leds; both share one blink phase so they never disagree
  always @(posedge clk_i) begin
    if (rst_i) begin
      id_led_front_o <= 1'b0;
      id_led_rear_o  <= 1'b0;
    end else begin
      id_led_front_o <= id_on_reg & blink_reg;
      id_led_rear_o  <= id_on_reg & blink_reg;
    end
  end

  // status led, highest severity first
  always @(posedge clk_i) begin
    if (rst_i) begin
      status_green_o <= 1'b0;
      status_amber_o <= 1'b0;
    end else begin
      if (fault_reg[`FPC_FLT_NOTRDY] || nmi_o) begin
        status_green_o <= 1'b0;
        status_amber_o <= 1'b0;
      end else if (fault_reg[`FPC_FLT_CRIT]) begin
        status_green_o <= 1'b0;
        status_amber_o <= 1'b1;
      end else if (fault_reg[`FPC_FLT_NONCRIT] || intr_db) begin
        status_green_o <= 1'b0;
        status_amber_o <= blink_reg;
      end else if (fault_reg[`FPC_FLT_DEGR]) begin
        status_green_o <= blink_reg;
        status_amber_o <= 1'b0;
      end else begin
        status_green_o <= 1'b1;
        status_amber_o <= 1'b0;
      end
    end
  end

  // read mux; unmapped offsets read zero
  always @* begin
    case (wb_adr_i)
      `FPC_ADR_CTRL:   rd_data = {29'h00000000, ctrl_reg};
      `FPC_ADR_IDENT:  rd_data = {22'h000000, id_timed_reg, id_on_reg, id_secs_reg};
      `FPC_ADR_STATUS: rd_data = {25'h0000000, nmi_o, sys_reset_o, intr_db,
                                  slp_db, nmi_db, rst_db, pwr_db};
      `FPC_ADR_EVENT:  rd_data = {29'h00000000, event_reg};
      `FPC_ADR_FAULT:  rd_data = {28'h0000000, fault_reg};
      default:         rd_data = 32'h00000000;
    endcase
  end
endmodule // fpc_front_panel

// ===== pkg/fpc_consts.vh
// constants for the front panel control block
`ifndef FPC_CONSTS_VH
`define FPC_CONSTS_VH

`define FPC_CLK_HZ        40000000
`define FPC_DEB_MS        25
`define FPC_DEB_CYC       ((`FPC_CLK_HZ / 1000) * `FPC_DEB_MS)
`define FPC_NMI_MS        200
`define FPC_NMI_CYC       ((`FPC_CLK_HZ / 1000) * `FPC_NMI_MS)
`define FPC_SEC_CYC       `FPC_CLK_HZ
`define FPC_BLINK_MS      500
`define FPC_BLINK_CYC     ((`FPC_CLK_HZ / 1000) * `FPC_BLINK_MS)
`define FPC_ID_DEF_S      8'h0F

`define FPC_ADR_CTRL      4'h0
`define FPC_ADR_IDENT     4'h1
`define FPC_ADR_STATUS    4'h2
`define FPC_ADR_EVENT     4'h3
`define FPC_ADR_FAULT     4'h4

`define FPC_CTRL_INTR_EN  0
`define FPC_CTRL_PWR_PROT 1
`define FPC_CTRL_RST_PROT 2

`define FPC_EV_VIOL       0
`define FPC_EV_NMI        1
`define FPC_EV_INTR       2

`define FPC_FLT_CRIT      0
`define FPC_FLT_NONCRIT   1
`define FPC_FLT_DEGR      2
`define FPC_FLT_NOTRDY    3

`define FPC_ID_OFF_CMD    8'h00
`define FPC_ID_DEFAULT    8'hFF
`define FPC_ID_FOREVER    8'hFE

`endif

// ===== testbench/fpc_fp_checker.sv
// concurrent checks on the front panel control ports
`timescale 1ns/100ps
module fpc_fp_checker #(
  parameter integer NMI_CYC = 20
) (
  // clock, reset and bus
  input wire        clk_i,
  input wire        rst_i,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [3:0]  wb_adr_i,
  input wire [3:0]  wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire        wb_ack_o,
  // panel and outputs
  input wire        pwr_button_i,
  input wire        rst_button_i,
  input wire        secure_mode_i,
  input wire        sleep_state_i,
  input wire        power_button_request_out_o,
  input wire        sys_reset_o,
  input wire        nmi_o,
  input wire        id_led_front_o,
  input wire        id_led_rear_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  reg [7:0] nmi_run_reg;
  always @(posedge clk_i) nmi_run_reg <= (rst_i || !nmi_o) ? 8'h00 : nmi_run_reg + 8'h01;
  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("bus request not acknowledged");
  // depth 8 assumes the bench debounce count of 8
  property p_pwr_deb; $rose(power_button_request_out_o) |-> $past(pwr_button_i, 8); endproperty
  a_pwr_deb: assert property (p_pwr_deb) else $error("power request without stable press");
  property p_pwr_lock;
    secure_mode_i && $past(secure_mode_i, 3) |-> !$rose(power_button_request_out_o);
  endproperty
  a_pwr_lock: assert property (p_pwr_lock) else $error("power request while locked");
  property p_rst_sleep; sleep_state_i && $past(sleep_state_i, 3) |-> !$rose(sys_reset_o); endproperty
  a_rst_sleep: assert property (p_rst_sleep) else $error("reset started while asleep");
  property p_rst_hold; rst_button_i [*8] ##0 sys_reset_o |=> sys_reset_o; endproperty
  a_rst_hold: assert property (p_rst_hold) else $error("reset released while held");
  property p_nmi_len; $fell(nmi_o) |-> nmi_run_reg == NMI_CYC; endproperty
  a_nmi_len: assert property (p_nmi_len) else $error("nmi pulse length wrong");
  property p_id_off;
    wb_ack_o && $past(wb_we_i && wb_sel_i[0] && wb_adr_i == 4'h1 && wb_dat_i[7:0] == 8'h00)
      |-> ##2 (!id_led_front_o) [*4];
  endproperty
  a_id_off: assert property (p_id_off) else $error("identify led not off after off write");
  property p_id_pair; id_led_front_o == id_led_rear_o; endproperty
  a_id_pair: assert property (p_id_pair) else $error("front and rear identify differ");
endmodule // fpc_fp_checker
bind fpc_front_panel fpc_fp_checker #(.NMI_CYC(NMI_CYC)) i_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
  .pwr_button_i(pwr_button_i), .rst_button_i(rst_button_i), .secure_mode_i(secure_mode_i),
  .sleep_state_i(sleep_state_i), .power_button_request_out_o(power_button_request_out_o),
  .sys_reset_o(sys_reset_o), .nmi_o(nmi_o), .id_led_front_o(id_led_front_o),
  .id_led_rear_o(id_led_rear_o));

// ===== testbench/fpc_panel_model.sv
// front panel partner: push buttons whose contacts chatter once per change
`timescale 1ns/100ps
module fpc_panel_model (
  // clock
  input  wire       clk_i,
  // intended levels, bit0 power, 1 reset, 2 nmi, 3 identify, 4 sleep
  input  wire [4:0] press_i,
  // contact levels seen by the controller
  output wire [4:0] btn_o
);
  reg [4:0] last_reg   = 5'h00;
  reg [4:0] bounce_reg = 5'h00;
  // one bounce after each edge, so a debouncer that samples once is caught
  always @(posedge clk_i) begin
    last_reg   <= press_i;
    bounce_reg <= press_i ^ last_reg;
  end
  assign btn_o = press_i ^ bounce_reg;
endmodule // fpc_panel_model

// ===== testbench/tb_front_panel_control.sv
// self-checking bench for front panel control
`timescale 1ns/100ps
module tb_front_panel_control;
  reg clk_i, rst_i, cyc, stb, we, intr, sec, lock, son, slp;
  reg [3:0] adr, sel;
  reg [31:0] dat, rd;
  reg [4:0] pb;
  wire [31:0] dat_o;
  wire [4:0] btn;
  wire ack, preq, sreq, srst, nmi, idf, grn, amb;
  integer err_count, compares, nf, ng, na, i;
  int eg[4] = '{0, 0, 8, 0};
  int ea[4] = '{16, 8, 0, 0};
  fpc_panel_model i_panel (.clk_i(clk_i), .press_i(pb), .btn_o(btn));
  fpc_front_panel #(.DEB_CYC(8), .NMI_CYC(20), .SEC_CYC(16), .BLINK_CYC(4)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .pwr_button_i(btn[0]),
    .rst_button_i(btn[1]), .nmi_button_i(btn[2]), .id_button_i(btn[3]),
    .sleep_button_i(btn[4]), .intrusion_i(intr), .secure_mode_i(sec), .panel_lockout_i(lock),
    .system_on_i(son), .sleep_state_i(slp), .power_button_request_out_o(preq),
    .sleep_request_o(sreq), .sys_reset_o(srst), .nmi_o(nmi), .id_led_front_o(idf),
    .id_led_rear_o(), .status_green_o(grn), .status_amber_o(amb));
  initial begin
    clk_i = 0;
    forever #12.5 clk_i = ~clk_i;
  end
  task stop_test; begin
    $display("mismatches %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  end endtask
  task chk(input string n, input [31:0] s, input [31:0] e); begin
    compares++;
    if (s !== e) begin
      err_count++;
      $display("ERROR %s expected %0h seen %0h", n, e, s);
    end
  end endtask
  task cyc_n(input integer n); repeat (n) @(posedge clk_i); endtask
  // bounded wait: a missing ack ends the run rather than hanging it
  task wb(input w, input [3:0] a, input [31:0] d); integer n; begin
    cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d;
    n = 0;
    do begin @(posedge clk_i); n++; end while (ack !== 1'b1 && n < 10);
    if (ack !== 1'b1) begin err_count++; stop_test; end
    rd = dat_o; cyc <= 0; stb <= 0;
    @(posedge clk_i);
  end endtask
  // 16 samples span two blink periods: blink gives 8, solid 16
  task sample; begin
    nf = 0; ng = 0; na = 0;
    repeat (16) begin
      @(posedge clk_i);
      nf += (idf === 1); ng += (grn === 1); na += (amb === 1);
    end
  end endtask
  task t_status; begin
    wb(0, 4'h1, 0); chk("ident_init", rd, 0);
    wb(0, 4'hF, 0); chk("unmapped", rd, 0);
    sample; chk("ready_grn", ng, 16);
    for (i = 0; i < 4; i++) begin
      wb(1, 4'h4, 1 << i); cyc_n(2); sample;
      chk("grn", ng, eg[i]);
      chk("amb", na, ea[i]);
    end
    wb(1, 4'h4, 0); wb(1, 4'h0, 1); intr <= 1; cyc_n(20); sample;
    chk("intr_amb", na, 8);
    wb(0, 4'h2, 0); chk("intr_stat", rd[4], 1);
    wb(0, 4'h3, 0); chk("intr_ev", rd[2], 1);
    intr <= 0; wb(1, 4'h3, 7); cyc_n(20);
  end endtask
  task t_power; begin
    pb <= 5'h10; cyc_n(20); chk("sleep", sreq, 1);
    pb <= 5'h11; cyc_n(20); chk("preq", preq, 1);
    chk("sleep_lost", sreq, 0);
    pb <= 0; sec <= 1; cyc_n(20);
    pb <= 5'h01; cyc_n(20); chk("preq_sec", preq, 0);
    wb(0, 4'h3, 0); chk("viol_pwr", rd[0], 1);
    pb <= 0; sec <= 0; lock <= 1; wb(1, 4'h3, 7); cyc_n(20);
    pb <= 5'h01; cyc_n(20); chk("preq_lock", preq, 0);
    pb <= 0; lock <= 0; cyc_n(20);
  end endtask
  task t_reset; begin
    pb <= 5'h02; cyc_n(6); pb <= 0; cyc_n(20); chk("rst_short", srst, 0);
    pb <= 5'h02; cyc_n(30); chk("rst_held", srst, 1);
    pb <= 0; cyc_n(20); chk("rst_rel", srst, 0);
    slp <= 1; pb <= 5'h02; cyc_n(20); chk("rst_slp", srst, 0);
    pb <= 0; slp <= 0; sec <= 1; cyc_n(20);
    pb <= 5'h02; cyc_n(20); chk("rst_sec", srst, 0);
    wb(0, 4'h3, 0); chk("viol_rst", rd[0], 1);
    pb <= 0; sec <= 0; wb(1, 4'h3, 7); cyc_n(20);
    pb <= 5'h04; cyc_n(14); chk("nmi_on", nmi, 1);
    cyc_n(25); chk("nmi_once", nmi, 0);
    pb <= 0; wb(0, 4'h3, 0); chk("nmi_ev", rd[1], 1);
  end endtask
  task t_ident; begin
    wb(1, 4'h1, 2); cyc_n(3); wb(0, 4'h1, 0); chk("id_on", rd[8], 1);
    sample; chk("id_blink", nf, 8);
    cyc_n(40); sample; chk("id_tmo", nf, 0);
    wb(1, 4'h1, 8'hFF); cyc_n(200); wb(0, 4'h1, 0); chk("id_def", rd[8], 1);
    cyc_n(80); wb(0, 4'h1, 0); chk("id_def_end", rd[8], 0);
    wb(1, 4'h1, 8'hFF); wb(1, 4'h1, 0); sample; chk("id_off", nf, 0);
    pb <= 5'h08; cyc_n(20); pb <= 0; cyc_n(300); sample;
    chk("id_btn", nf, 8);
    pb <= 5'h08; cyc_n(20); pb <= 0; cyc_n(20); sample; chk("id_btn_off", nf, 0);
  end endtask
  initial begin
    err_count = 0; compares = 0; rst_i = 1; cyc = 0; stb = 0; we = 0; adr = 0;
    sel = 4'hF; dat = 0; pb = 0; intr = 0; sec = 0; lock = 0; son = 0; slp = 0;
    repeat (4) @(posedge clk_i);
    rst_i <= 0;
    t_status; t_power; t_reset; t_ident;
    stop_test;
  end
endmodule // tb_front_panel_control
